// [lcm_pkg.sv]
// Constants, types and field layouts of the link congestion and error monitor
package lcm_pkg;
  // ==========================================================
  // Timing
  localparam int CLK_NS = 10;
  localparam int OCTET_NS = 125000;
  localparam int OCTET_CYC = (OCTET_NS + CLK_NS - 1) / CLK_NS;
  localparam int HYST_NS = 1000000;
  localparam int HYST_CYC = (HYST_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [16:0] PN_LAST = 17'h0FFFF;
  localparam logic [16:0] PE_LAST = 17'h00FFF;
  // ==========================================================
  // Monitor figures
  localparam logic [7:0] D_LAST = 8'hFF;
  localparam logic [3:0] N_LAST = 4'hF;
  localparam logic [6:0] T_HI = 7'h40;
  localparam logic [6:0] T_LO = 7'h20;
  localparam logic [2:0] TIN = 3'h4;
  localparam logic [2:0] TIE = 3'h1;
  localparam logic [2:0] M_ABORT = 3'h5;
  localparam logic [5:0] LI_SF1 = 6'h01;
  localparam logic [5:0] LI_SF2 = 6'h02;
  // ==========================================================
  // Register map
  localparam logic [2:0] ADR_CFG = 3'h0;
  localparam logic [2:0] ADR_STAT = 3'h1;
  localparam logic [2:0] ADR_SUERM = 3'h2;
  localparam logic [2:0] ADR_AERM = 3'h3;
  localparam int CFG_RATE = 0;
  localparam int CFG_EMER = 1;
  localparam int CFG_PCR = 2;
  localparam logic [2:0] CFG_RST = 3'h1;
  localparam int STAT_FAIL = 3;
  // ==========================================================
  // Types
  typedef enum logic [2:0] {
    SI_O = 3'h0, SI_N = 3'h1, SI_E = 3'h2,
    SI_OS = 3'h3, SI_PO = 3'h4, SI_B = 3'h5
  } lcm_si_type;
  typedef enum logic [1:0] {PV_IDLE, PV_RUN, PV_ABORT} lcm_pv_type;
  typedef struct packed {
    logic [6:0] bsn;
    logic bib;
  } lcm_bk_type;
  typedef struct packed {
    logic valid;
    logic err;
    logic ocm;
    logic octet;
    logic [5:0] li;
    logic [7:0] sf0;
    lcm_bk_type bk;
  } lcm_rx_type;
endpackage : lcm_pkg

// [lcm_top.sv]
// Link congestion control, busy supervision, error rate monitors
//
// The address-and-strobe port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
module lcm_top import lcm_pkg::*; #(
  parameter int OCTET_CYC_P = OCTET_CYC,
  parameter int HYST_CYC_P = HYST_CYC
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_b,
  // Register port
  input wire logic [2:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  // Link state and timer lengths
  input wire logic i_in_service,
  input wire logic i_proving,
  input wire logic i_cong_raw,
  input wire logic [31:0] i_t5_cyc,
  input wire logic [31:0] i_t6_cyc,
  // Receive side
  input wire lcm_rx_type i_rx,
  input wire logic i_ack_pos,
  input wire logic i_ack_neg,
  // Transmit side
  input wire lcm_bk_type i_bk_next,
  input wire logic i_tx_sent,
  input wire logic [2:0] i_tx_ind,
  // Congestion and busy outputs
  output logic o_congested,
  output logic o_lssu_busy,
  output logic [7:0] o_tx_sf,
  output lcm_bk_type o_tx_bk,
  output lcm_bk_type o_rx_bk,
  output logic o_t7_restart,
  output logic o_t6_run,
  output logic o_link_fail,
  // Decoded received status
  output logic [2:0] o_rx_si,
  output logic o_rx_si_valid,
  // Monitor outputs
  output logic o_erh,
  output logic o_prove_abort,
  output logic o_prove_ok,
  output logic o_oos
);

  // ==========================================================
  // Elaboration checks
  if (OCTET_CYC_P < 2 || OCTET_CYC_P > 16383) begin : g_chk_oct
    $error("OCTET_CYC_P out of range");
  end
  if (HYST_CYC_P < 1 || HYST_CYC_P > 131071) begin : g_chk_hys
    $error("HYST_CYC_P out of range");
  end
  localparam logic [13:0] OLIM = 14'(OCTET_CYC_P - 1);
  localparam logic [16:0] HLIM = 17'(HYST_CYC_P - 1);

  // ==========================================================
  // State
  typedef struct packed {
    logic [7:0] rdata;
    logic [2:0] cfg;
    logic fail_flag;
    logic cong;
    logic [16:0] hcnt;
    logic [31:0] t5cnt;
    logic busy_p;
    lcm_bk_type last;
    lcm_bk_type txbk;
    lcm_bk_type rxbk;
    logic [7:0] sf;
    logic t7p;
    logic t6run;
    logic [31:0] t6cnt;
    logic failp;
    logic [2:0] si;
    logic siv;
    logic svc_d;
    logic [6:0] cs;
    logic [7:0] dcnt;
    logic [3:0] ocnt;
    logic erh;
    logic prv_d;
    lcm_pv_type pv;
    logic [13:0] odiv;
    logic [16:0] pcnt;
    logic [2:0] ca;
    logic [2:0] cp;
    logic bad_si;
    logic abortp;
    logic okp;
    logic oosp;
  } lcm_st_type;

  lcm_st_type st_reg;
  lcm_st_type st_next;

  // Received event decode
  logic lssu;
  logic [2:0] rx_si;
  logic rx_busy;
  logic t6_stop;
  logic [6:0] tlim;
  logic oct_inc;
  logic tick;
  logic exp_p;
  logic err_ev;

  // Status unit by length, first octet only, spare bits dropped
  assign lssu = i_rx.valid && (i_rx.li == LI_SF1 || i_rx.li == LI_SF2);
  assign rx_si = i_rx.sf0[2:0];
  assign rx_busy = lssu && rx_si == SI_B;
  // Method-dependent T6 stop condition
  assign t6_stop = st_reg.cfg[CFG_PCR] ? i_ack_pos : (i_ack_pos || i_ack_neg);
  assign tlim = st_reg.cfg[CFG_RATE] ? T_HI : T_LO;
  // One count per 16 octets in octet counting mode
  assign oct_inc = i_rx.ocm && i_rx.octet && st_reg.ocnt == N_LAST;
  assign err_ev = (i_rx.err && !i_rx.ocm) || oct_inc;
  // Octet-time tick and proving period end
  assign tick = st_reg.odiv == OLIM;
  assign exp_p = tick && st_reg.pcnt == (st_reg.cfg[CFG_EMER] ? PE_LAST : PN_LAST);

  // ==========================================================
  // Next state
  always_comb begin
    st_next = st_reg;
    st_next.rdata = 8'h00;
    st_next.busy_p = 1'b0;
    st_next.t7p = 1'b0;
    st_next.failp = 1'b0;
    st_next.siv = 1'b0;
    st_next.abortp = 1'b0;
    st_next.okp = 1'b0;
    st_next.oosp = 1'b0;
    st_next.svc_d = i_in_service;
    st_next.prv_d = i_proving;

    // Register reads, data in the following cycle only
    if (i_rd) begin
      if (i_addr == ADR_CFG) begin
        st_next.rdata = {5'h00, st_reg.cfg};
      end else if (i_addr == ADR_STAT) begin
        st_next.rdata = {3'h0, st_reg.pv == PV_ABORT, st_reg.fail_flag,
                         st_reg.t6run, st_reg.erh, st_reg.cong};
      end else if (i_addr == ADR_SUERM) begin
        st_next.rdata = {1'b0, st_reg.cs};
      end else if (i_addr == ADR_AERM) begin
        st_next.rdata = {1'b0, st_reg.cp, 1'b0, st_reg.ca};
      end
    end
    // Register writes; failure flag clears by writing one
    if (i_wr) begin
      if (i_addr == ADR_CFG) begin
        st_next.cfg = i_wdata[2:0];
      end else if (i_addr == ADR_STAT && i_wdata[STAT_FAIL]) begin
        st_next.fail_flag = 1'b0;
      end
    end

    // Congestion filter: input must hold for the dwell time
    if (i_cong_raw != st_reg.cong) begin
      if (st_reg.hcnt == HLIM) begin
        st_next.cong = i_cong_raw;
        st_next.hcnt = 17'h00000;
      end else begin
        st_next.hcnt = st_reg.hcnt + 17'h00001;
      end
    end else begin
      st_next.hcnt = 17'h00000;
    end

    // Periodic busy request while congested
    if (st_reg.cong) begin
      if (st_reg.t5cnt == 32'h0) begin
        st_next.busy_p = 1'b1;
        st_next.t5cnt = i_t5_cyc - 32'h1;
      end else begin
        st_next.t5cnt = st_reg.t5cnt - 32'h1;
      end
    end else begin
      st_next.t5cnt = 32'h0;
    end
    // Outgoing status octet
    st_next.sf = {5'h00, st_reg.cong ? SI_B : i_tx_ind};

    // Backward values: sent ones live when clear, frozen while congested; received ones taken from each valid unit
    if (i_tx_sent && !st_reg.cong) begin
      st_next.last = st_reg.txbk;
    end
    st_next.txbk = st_reg.cong ? st_reg.last : i_bk_next;
    if (i_rx.valid) begin
      st_next.rxbk = i_rx.bk;
    end
    // Received status and busy supervision
    if (lssu) begin
      st_next.si = rx_si;
      st_next.siv = 1'b1;
    end
    if (rx_busy) begin
      st_next.t7p = 1'b1;
    end
    if (st_reg.t6run) begin
      if (t6_stop) begin
        st_next.t6run = 1'b0;
      end else if (st_reg.t6cnt == i_t6_cyc - 32'h1) begin
        st_next.t6run = 1'b0;
        st_next.failp = 1'b1;
        st_next.fail_flag = 1'b1;
      end else begin
        st_next.t6cnt = st_reg.t6cnt + 32'h1;
      end
    end else if (rx_busy) begin
      st_next.t6run = 1'b1;
      st_next.t6cnt = 32'h0;
    end
    // Shared octet counter for octet counting mode
    if (!i_rx.ocm) begin
      st_next.ocnt = 4'h0;
    end else if (i_rx.octet) begin
      st_next.ocnt = st_reg.ocnt + 4'h1;
    end
    // In-service monitor
    if (i_in_service && !st_reg.svc_d) begin
      st_next.cs = 7'h00;
      st_next.dcnt = 8'h00;
    end else if (i_in_service) begin
      if (i_rx.valid || i_rx.err) begin
        st_next.dcnt = st_reg.dcnt + 8'h01;
      end
      if (err_ev && st_reg.cs != tlim) begin
        st_next.cs = st_reg.cs + 7'h01;
      end else if (!err_ev && (i_rx.valid || i_rx.err) &&
                   st_reg.dcnt == D_LAST && st_reg.cs != 7'h00) begin
        st_next.cs = st_reg.cs - 7'h01;
      end
    end
    st_next.erh = i_in_service && st_next.cs == tlim;
    // Proving monitor
    st_next.odiv = tick ? 14'h0000 : st_reg.odiv + 14'h0001;
    if (tick) begin
      st_next.pcnt = exp_p ? 17'h00000 : st_reg.pcnt + 17'h00001;
    end
    if (!i_proving) begin
      st_next.pv = PV_IDLE;
    end else if (!st_reg.prv_d) begin
      st_next.pv = PV_RUN;
      st_next.ca = 3'h0;
      st_next.cp = 3'h0;
      st_next.odiv = 14'h0000;
      st_next.pcnt = 17'h00000;
      st_next.bad_si = 1'b0;
    end else begin
      case (st_reg.pv)
        PV_RUN: begin
          if (lssu && (rx_si == SI_O || rx_si == SI_OS)) begin
            st_next.bad_si = 1'b1;
          end
          if (err_ev) begin
            st_next.ca = st_reg.ca + 3'h1;
          end
          if (err_ev && st_reg.ca + 3'h1 ==
              (st_reg.cfg[CFG_EMER] ? TIE : TIN)) begin
            st_next.abortp = 1'b1;
            st_next.cp = st_reg.cp + 3'h1;
            if (st_reg.cp + 3'h1 == M_ABORT) begin
              st_next.oosp = 1'b1;
              st_next.pv = PV_IDLE;
            end else begin
              st_next.pv = PV_ABORT;
            end
          end else if (exp_p) begin
            if (!st_reg.bad_si) begin
              st_next.okp = 1'b1;
              st_next.pv = PV_IDLE;
            end else begin
              st_next.bad_si = 1'b0;
              st_next.ca = 3'h0;
            end
          end
        end
        PV_ABORT: begin
          if ((i_rx.valid && !i_rx.ocm) || exp_p) begin
            st_next.pv = PV_RUN;
            st_next.ca = 3'h0;
            st_next.pcnt = 17'h00000;
            st_next.odiv = 14'h0000;
            st_next.bad_si = 1'b0;
          end
        end
        default: begin
          st_next.pv = PV_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      st_reg <= '0;
      st_reg.cfg <= CFG_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs straight from the state register
  assign o_rdata = st_reg.rdata;
  assign o_congested = st_reg.cong;
  assign o_lssu_busy = st_reg.busy_p;
  assign o_tx_sf = st_reg.sf;
  assign o_tx_bk = st_reg.txbk;
  assign o_rx_bk = st_reg.rxbk;
  assign o_t7_restart = st_reg.t7p;
  assign o_t6_run = st_reg.t6run;
  assign o_link_fail = st_reg.failp;
  assign o_rx_si = st_reg.si;
  assign o_rx_si_valid = st_reg.siv;
  assign o_erh = st_reg.erh;
  assign o_prove_abort = st_reg.abortp;
  assign o_prove_ok = st_reg.okp;
  assign o_oos = st_reg.oosp;

  // ==========================================================
  // Assertions
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_b);

  AST_BUSY_ONSET: assert property (
    $rose(st_reg.cong) |=> o_lssu_busy)
    else $error("no busy unit at congestion onset");
  AST_NO_BUSY_CLEAR: assert property (
    !st_reg.cong |=> !o_lssu_busy)
    else $error("busy unit sent while not congested");
  AST_FREEZE_BK: assert property (
    st_reg.cong && $past(st_reg.cong) && $past(st_reg.cong, 2) |-> $stable(o_tx_bk))
    else $error("backward values moved during congestion");
  AST_RX_BK: assert property (
    i_rx.valid |=> o_rx_bk == $past(i_rx.bk))
    else $error("received backward values not taken");
  AST_T7: assert property (
    rx_busy |=> o_t7_restart)
    else $error("busy unit did not restart T7");
  AST_T6_START: assert property (
    rx_busy && !st_reg.t6run |=> o_t6_run ##0 st_reg.t6cnt == 32'h0)
    else $error("first busy did not start T6");
  AST_T6_STOP: assert property (
    st_reg.t6run && t6_stop |=> !o_t6_run && !o_link_fail)
    else $error("T6 not stopped by acknowledgement");
  AST_SUERM_CLR: assert property (
    $rose(i_in_service) |=> st_reg.cs == 7'h00)
    else $error("in-service count not cleared");
  AST_CS_BOUND: assert property (
    st_reg.svc_d |-> st_reg.cs <= tlim)
    else $error("in-service count above threshold");
  AST_AERM_CLR: assert property (
    $rose(i_proving) |=> st_reg.ca == 3'h0 && st_reg.pv == PV_RUN)
    else $error("proving count not cleared on entry");
  AST_OOS: assert property (
    o_oos |-> st_reg.cp == M_ABORT && $past(st_reg.pv) == PV_RUN)
    else $error("out of service without five aborts");
  AST_OK: assert property (
    o_prove_ok |-> !$past(st_reg.bad_si) && $past(exp_p))
    else $error("proving success without clean expiry");
  COV_BUSY: cover property (st_reg.cong ##1 o_lssu_busy);
  COV_FAIL: cover property (o_link_fail);
  COV_OK: cover property (o_prove_ok);
  COV_OOS: cover property (o_oos);
endmodule : lcm_top

// [lcm_remote.sv]
// Remote signalling link terminal model that sends units toward the monitor
`timescale 1ns/1ps
module lcm_remote import lcm_pkg::*; (
  // Clock
  input wire logic i_clk,
  // Received unit stream
  output lcm_rx_type o_rx
);
  // Extra idle cycles before each unit, to model a slow far end
  int slow = 0;
  initial o_rx = '0;
  // ==========================================================
  // Unit transfer
  // One unit per call; released li, sf0 and bk show the inverse, never the last value; valid and err drop to zero
  task automatic unit(input logic [5:0] li, input logic [7:0] sf0, input lcm_bk_type bk,
                      input logic bad);
    repeat (slow) @(posedge i_clk);
    @(posedge i_clk);
    o_rx.valid <= !bad;
    o_rx.err <= bad;
    o_rx.li <= li;
    o_rx.sf0 <= sf0;
    o_rx.bk <= bk;
    @(posedge i_clk);
    o_rx.valid <= 1'b0;
    o_rx.err <= 1'b0;
    o_rx.li <= ~li;
    o_rx.sf0 <= ~sf0;
    o_rx.bk <= ~bk;
  endtask : unit
  // Status unit of one or two octets, spare bits all set
  task automatic status(input logic [2:0] code, input logic two, input lcm_bk_type bk);
    unit(two ? LI_SF2 : LI_SF1, {5'h1F, code}, bk, 1'b0);
  endtask : status
  // ==========================================================
  // Octet counting
  // Octet counting mode with a run of octet ticks
  task automatic octets(input int n);
    @(posedge i_clk);
    o_rx.ocm <= 1'b1;
    repeat (n) begin
      @(posedge i_clk);
      o_rx.octet <= 1'b1;
      @(posedge i_clk);
      o_rx.octet <= 1'b0;
    end
    @(posedge i_clk);
    o_rx.ocm <= 1'b0;
  endtask : octets
endmodule : lcm_remote

// [test_lcm_top.sv]
// Self-checking bench of the link congestion and error monitor
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin bad_count++; \
  $display("ERROR %s expected %0h seen %0h", nm, ex, got); end end
module test_lcm_top import lcm_pkg::*;;
  logic i_clk = 1'b0;
  logic i_rst_b = 1'b0;
  logic [2:0] i_addr = 3'h0;
  logic [7:0] i_wdata = 8'h00;
  logic i_wr = 1'b0, i_rd = 1'b0;
  logic i_in_service = 1'b0, i_proving = 1'b0, i_cong_raw = 1'b0;
  logic [31:0] i_t5_cyc = 32'h0000000A;
  logic [31:0] i_t6_cyc = 32'h000000C8;
  lcm_rx_type i_rx;
  logic i_ack_pos = 1'b0, i_ack_neg = 1'b0, i_tx_sent = 1'b0;
  lcm_bk_type i_bk_next = 8'h00;
  logic [2:0] i_tx_ind = SI_N;
  logic [7:0] o_rdata, o_tx_sf;
  lcm_bk_type o_tx_bk, o_rx_bk;
  logic [2:0] o_rx_si;
  logic o_congested, o_lssu_busy, o_t7_restart, o_t6_run, o_link_fail, o_rx_si_valid;
  logic o_erh, o_prove_abort, o_prove_ok, o_oos;
  int bad_count = 0, checked = 0, cyc = 0, t_ok = 0;
  int n_busy = 0, n_t7 = 0, n_fail = 0, n_abort = 0, n_oos = 0, n_ok = 0;
  localparam int OCT = 4;
  // Any unknown on the event pulses after reset is a mismatch
  logic pulses_x;
  assign pulses_x = $isunknown({o_lssu_busy, o_t7_restart, o_link_fail, o_prove_abort,
                                o_oos, o_prove_ok});
  // ==========================================================
  // Design and far end
  lcm_top #(.OCTET_CYC_P(OCT), .HYST_CYC_P(3)) dut (.i_clk(i_clk), .i_rst_b(i_rst_b),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_in_service(i_in_service), .i_proving(i_proving), .i_cong_raw(i_cong_raw),
    .i_t5_cyc(i_t5_cyc), .i_t6_cyc(i_t6_cyc), .i_rx(i_rx), .i_ack_pos(i_ack_pos),
    .i_ack_neg(i_ack_neg), .i_bk_next(i_bk_next), .i_tx_sent(i_tx_sent),
    .i_tx_ind(i_tx_ind), .o_congested(o_congested), .o_lssu_busy(o_lssu_busy),
    .o_tx_sf(o_tx_sf), .o_tx_bk(o_tx_bk), .o_rx_bk(o_rx_bk), .o_t7_restart(o_t7_restart),
    .o_t6_run(o_t6_run), .o_link_fail(o_link_fail), .o_rx_si(o_rx_si),
    .o_rx_si_valid(o_rx_si_valid), .o_erh(o_erh), .o_prove_abort(o_prove_abort),
    .o_prove_ok(o_prove_ok), .o_oos(o_oos));
  lcm_remote rem (.i_clk(i_clk), .o_rx(i_rx));
  // Clock
  always #5 i_clk = ~i_clk;
  // Pulse counters, cycle stamp and run limit
  always @(posedge i_clk) begin
    cyc++;
    if (i_rst_b) `CHK("pulses_known", 1'b0, pulses_x)
    if (o_lssu_busy === 1'b1) n_busy++;
    if (o_t7_restart === 1'b1) n_t7++;
    if (o_link_fail === 1'b1) n_fail++;
    if (o_prove_abort === 1'b1) n_abort++;
    if (o_oos === 1'b1) n_oos++;
    if (o_prove_ok === 1'b1) begin
      n_ok++;
      t_ok = cyc;
    end
    if (cyc == 60000) begin
      $display("ERROR cycle_limit expected %0d seen %0d", 59999, cyc);
      bad_count++;
      conclude();
    end
  end
  // ==========================================================
  // Access tasks
  task automatic reg_wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask : reg_wr
  task automatic reg_rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge i_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1;
    d = o_rdata;
  endtask : reg_rd
  task automatic ack(input logic neg);
    @(posedge i_clk);
    i_ack_pos <= !neg;
    i_ack_neg <= neg;
    @(posedge i_clk);
    i_ack_pos <= 1'b0;
    i_ack_neg <= 1'b0;
    repeat (2) @(posedge i_clk);
    #1;
  endtask : ack
  task automatic conclude;
    if (bad_count == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : conclude
  // ==========================================================
  // Test sequence
  initial begin
    logic [7:0] d;
    int t0;
    int ex;
    repeat (2) @(posedge i_clk);
    i_rst_b <= 1'b1;
    @(posedge i_clk);
    // Reset values, read-only and unmapped places
    reg_rd(ADR_CFG, d);
    `CHK("cfg", 8'h01, d)
    reg_wr(ADR_SUERM, 8'h11);
    reg_wr(3'h7, 8'hFF);
    reg_rd(ADR_SUERM, d);
    `CHK("suerm_ro", 8'h00, d)
    reg_rd(3'h7, d);
    `CHK("unmapped", 8'h00, d)
    // Every status code, both lengths, spare bits set, slow far end
    rem.slow = 1;
    for (int c = 0; c < 6; c++) begin
      rem.status(3'(c), 1'(c), 8'(c + 8'h40));
      #1;
      `CHK("rx_si", 3'(c), o_rx_si)
      `CHK("rx_si_valid", 1'b1, o_rx_si_valid)
      `CHK("rx_bk", 8'(c + 8'h40), o_rx_bk)
    end
    rem.slow = 0;
    `CHK("t6_start", 1'b1, o_t6_run)
    rem.unit(6'h03, 8'h05, 8'h00, 1'b0);
    #1;
    `CHK("li3_ignored", 1'b0, o_rx_si_valid)
    `CHK("t7_count", 1, n_t7)
    // Busy supervision stop under both correction methods
    ack(1'b1);
    `CHK("basic_neg_stops", 1'b0, o_t6_run)
    rem.status(SI_B, 1'b0, 8'h00);
    #1;
    `CHK("t7_pulse", 1'b1, o_t7_restart)
    @(posedge i_clk);
    #1;
    `CHK("t7_count2", 2, n_t7)
    reg_wr(ADR_CFG, 8'h05);
    ack(1'b1);
    `CHK("pcr_neg_keeps", 1'b1, o_t6_run)
    ack(1'b0);
    `CHK("pcr_pos_stops", 1'b0, o_t6_run)
    rem.status(SI_B, 1'b1, 8'h00);
    repeat (i_t6_cyc - 4) @(posedge i_clk);
    #1;
    `CHK("no_early_fail", 0, n_fail)
    repeat (8) @(posedge i_clk);
    #1;
    `CHK("fail_once", 1, n_fail)
    reg_rd(ADR_STAT, d);
    `CHK("stat_fail", 1'b1, d[STAT_FAIL])
    reg_wr(ADR_STAT, 8'h08);
    reg_rd(ADR_STAT, d);
    `CHK("fail_clear", 1'b0, d[STAT_FAIL])
    // Congestion: glitch, onset, periodic busy, frozen backward values, abatement
    @(posedge i_clk);
    i_cong_raw <= 1'b1;
    @(posedge i_clk);
    i_cong_raw <= 1'b0;
    i_bk_next <= 8'h5A;
    repeat (6) @(posedge i_clk);
    #1;
    `CHK("glitch", 1'b0, o_congested)
    `CHK("bk_follow", 8'h5A, o_tx_bk)
    @(posedge i_clk);
    i_tx_sent <= 1'b1;
    @(posedge i_clk);
    i_tx_sent <= 1'b0;
    i_cong_raw <= 1'b1;
    i_bk_next <= 8'h33;
    for (int w = 0; w < 10 && o_congested !== 1'b1; w++) @(posedge i_clk);
    t0 = n_busy;
    for (int k = 0; k < 38; k++) begin
      @(posedge i_clk);
      i_bk_next <= 8'(k);
      #1;
      `CHK("bk_frozen", 8'h5A, o_tx_bk)
      if (k == 31 || k == 37) `CHK("busy_count", 4, n_busy - t0)
    end
    `CHK("tx_sf_busy", {5'h00, SI_B}, o_tx_sf)
    @(posedge i_clk);
    i_cong_raw <= 1'b0;
    for (int w = 0; w < 10 && o_congested !== 1'b0; w++) @(posedge i_clk);
    t0 = n_busy;
    repeat (30) @(posedge i_clk);
    #1;
    `CHK("busy_stopped", t0, n_busy)
    `CHK("bk_resumed", 8'h25, o_tx_bk)
    `CHK("tx_sf_normal", 8'h01, o_tx_sf)
    // In-service monitor at the lower rate threshold
    reg_wr(ADR_CFG, 8'h00);
    @(posedge i_clk);
    i_in_service <= 1'b1;
    rem.octets(32);
    reg_rd(ADR_SUERM, d);
    `CHK("octet_count", 8'h02, d)
    repeat (256) rem.unit(6'h00, 8'h00, 8'h00, 1'b0);
    reg_rd(ADR_SUERM, d);
    `CHK("decrement", 8'h01, d)
    repeat (40) rem.unit(6'h00, 8'h00, 8'h00, 1'b1);
    reg_rd(ADR_SUERM, d);
    `CHK("saturate", 8'h20, d)
    `CHK("erh", 1'b1, o_erh)
    @(posedge i_clk);
    i_in_service <= 1'b0;
    repeat (3) rem.unit(6'h00, 8'h00, 8'h00, 1'b1);
    reg_rd(ADR_SUERM, d);
    `CHK("idle_monitor", 8'h20, d)
    `CHK("erh_off", 1'b0, o_erh)
    @(posedge i_clk);
    i_in_service <= 1'b1;
    repeat (256) rem.unit(6'h00, 8'h00, 8'h00, 1'b0);
    reg_rd(ADR_SUERM, d);
    `CHK("clear_floor", 8'h00, d)
    // Proving monitor: normal threshold, emergency aborts, period length
    @(posedge i_clk);
    i_in_service <= 1'b0;
    i_proving <= 1'b1;
    t0 = n_abort;
    repeat (3) rem.unit(6'h00, 8'h00, 8'h00, 1'b1);
    repeat (2) @(posedge i_clk);
    #1;
    `CHK("no_abort3", t0, n_abort)
    rem.unit(6'h00, 8'h00, 8'h00, 1'b1);
    repeat (3) @(posedge i_clk);
    #1;
    `CHK("abort4", t0 + 1, n_abort)
    @(posedge i_clk);
    i_proving <= 1'b0;
    reg_wr(ADR_CFG, 8'h02);
    @(posedge i_clk);
    i_proving <= 1'b1;
    t0 = n_abort;
    repeat (5) begin
      rem.unit(6'h00, 8'h00, 8'h00, 1'b1);
      repeat (2) @(posedge i_clk);
      rem.unit(6'h00, 8'h00, 8'h00, 1'b0);
    end
    repeat (3) @(posedge i_clk);
    #1;
    `CHK("aborts", 5, n_abort - t0)
    `CHK("oos", 1, n_oos)
    reg_rd(ADR_AERM, d);
    `CHK("aerm", 8'h51, d)
    @(posedge i_clk);
    i_proving <= 1'b0;
    @(posedge i_clk);
    i_proving <= 1'b1;
    t0 = cyc;
    ex = 2 * (int'(PE_LAST) + 1) * OCT;
    rem.status(SI_O, 1'b0, 8'h00);
    repeat (ex + 40) @(posedge i_clk);
    #1;
    `CHK("prove_ok", 1, n_ok)
    `CHK("period", 1'b1, (t_ok - t0 > ex - 16) && (t_ok - t0 < ex + 16))
    conclude();
  end
endmodule : test_lcm_top
